// File: logic/ar_indirect_defines.svh
// Constants of the auxiliary-register indirect address generator
`ifndef AR_INDIRECT_DEFINES_SVH
`define AR_INDIRECT_DEFINES_SVH
`define AG_ADDR_W 23
`define AG_WORD_W 16
`define AG_NPTR 8
`define AG_SEL_W 3
`define AG_STEP_SHORT 23'h0_0001
`define AG_STEP_LONG 23'h0_0002
`define AG_PTR_RST 23'h0_0000
`define AG_ZERO_SEL 3'h0
`endif

// File: logic/ar_indirect_pkg.sv
// Types shared by the address generator and its bench
`include "ar_indirect_defines.svh"
package ar_indirect_pkg;
	typedef enum logic [2:0] {
		OP_PLAIN = 3'b000,
		OP_POST_INC = 3'b001,
		OP_POST_DEC = 3'b010,
		OP_POST_ADD = 3'b011,
		OP_BASE_K = 3'b100,
		OP_PRE_K = 3'b101
	} op_t;
	typedef enum logic [1:0] {
		ACC_WORD = 2'b00,
		ACC_LONG = 2'b01,
		ACC_BIT1 = 2'b10,
		ACC_BIT2 = 2'b11
	} access_t;
	typedef enum logic [1:0] {
		SP_DATA = 2'b00,
		SP_MMR = 2'b01,
		SP_RBIT = 2'b10,
		SP_IO = 2'b11
	} space_t;
endpackage

// File: logic/ar_pointer_file.sv
// Extended pointer registers with registered, write-through read ports
`timescale 1ns/1ps
`include "ar_indirect_defines.svh"
module ar_pointer_file #(
	parameter int NPTR = `AG_NPTR,
	parameter int W = `AG_ADDR_W,
	parameter int NRD = 2
) (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_we,
	input wire logic [$clog2(NPTR)-1:0] i_wsel,
	input wire logic [W-1:0] i_wdata,
	input wire logic [NRD-1:0][$clog2(NPTR)-1:0] i_rsel,
	output logic [NRD-1:0][W-1:0] o_rdata
);
	typedef struct packed {
		logic [NPTR-1:0][W-1:0] mem;
		logic [NRD-1:0][W-1:0] rd;
	} pf_st_t;

	pf_st_t s_q;
	pf_st_t s_d;
	logic [NRD-1:0][W-1:0] rd_next;

	// A write in the same cycle is passed straight to the read register
	for (genvar k = 0; k < NRD; k++) begin : g_rd
		assign rd_next[k] = (i_we && i_wsel == i_rsel[k]) ? i_wdata :
			s_q.mem[i_rsel[k]];
	end

	always_comb begin
		s_d = s_q;
		s_d.rd = rd_next;
		if (i_we) begin
			s_d.mem[i_wsel] = i_wdata;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_rdata = s_q.rd;
endmodule

// File: logic/ar_indirect_address_gen.sv
// Single-pointer indirect operand address generation and pointer update
`timescale 1ns/1ps
`include "ar_indirect_defines.svh"
module ar_indirect_address_gen (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_req_valid,
	input wire ar_indirect_pkg::op_t i_op,
	input wire logic [`AG_SEL_W-1:0] i_ptr_sel,
	input wire ar_indirect_pkg::access_t i_access,
	input wire ar_indirect_pkg::space_t i_space,
	input wire logic i_pointer_mode_select,
	input wire logic i_legacy_compat_mode,
	input wire logic [`AG_WORD_W-1:0] i_temp_reg_zero,
	input wire logic [`AG_WORD_W-1:0] i_ext_word,
	input wire logic i_ext_valid,
	input wire logic i_parallel,
	input wire logic i_ptr_ld_en,
	input wire logic [`AG_SEL_W-1:0] i_ptr_ld_sel,
	input wire logic [`AG_ADDR_W-1:0] i_ptr_ld_data,
	output logic o_addr_vld,
	output logic [`AG_ADDR_W-1:0] o_addr,
	output ar_indirect_pkg::space_t o_space,
	output logic o_fault
);
	import ar_indirect_pkg::*;

	typedef struct packed {
		logic vld;
		op_t op;
		logic [`AG_SEL_W-1:0] sel;
		access_t acc;
		space_t spc;
		logic mode;
		logic legacy;
		logic [`AG_WORD_W-1:0] tmp;
		logic [`AG_WORD_W-1:0] konst;
		logic ext_ok;
		logic par;
		logic out_vld;
		logic [`AG_ADDR_W-1:0] out_addr;
		space_t out_spc;
		logic out_fault;
	} ag_st_t;

	ag_st_t s_q;
	ag_st_t s_d;
	logic [1:0][`AG_ADDR_W-1:0] rd_data;
	logic [1:0][`AG_SEL_W-1:0] rd_sel;
	logic [`AG_ADDR_W-1:0] ptr_rd;
	logic [`AG_ADDR_W-1:0] zero_rd;
	logic is_k;
	logic bad;
	logic upd_we;
	logic [`AG_ADDR_W-1:0] upd_data;
	logic [`AG_ADDR_W-1:0] step;
	logic [`AG_ADDR_W-1:0] offset;
	logic [`AG_ADDR_W-1:0] addr;
	logic pf_we;
	logic [`AG_SEL_W-1:0] pf_wsel;
	logic [`AG_ADDR_W-1:0] pf_wdata;

	function automatic logic [`AG_ADDR_W-1:0] sext(
		input logic [`AG_WORD_W-1:0] v
	);
		return {{(`AG_ADDR_W - `AG_WORD_W){v[`AG_WORD_W-1]}}, v};
	endfunction

	assign ptr_rd = rd_data[0];
	assign zero_rd = rd_data[1];
	assign rd_sel[0] = i_ptr_sel;
	assign rd_sel[1] = `AG_ZERO_SEL;

	always_comb begin
		is_k = (s_q.op == OP_PRE_K) || (s_q.op == OP_BASE_K);
		// Long step for 32-bit words and bit pairs
		step = (s_q.acc == ACC_LONG || s_q.acc == ACC_BIT2) ?
			`AG_STEP_LONG : `AG_STEP_SHORT;
		// Constant from the extension; post-add source by legacy bit
		if (is_k) begin
			offset = sext(s_q.konst);
		end else if (s_q.legacy) begin
			offset = zero_rd;
		end else begin
			offset = sext(s_q.tmp);
		end
		// Constant operands: no I/O, need extension, never paired
		// Other operands belong to the control set only
		if (is_k) begin
			bad = (s_q.spc == SP_IO) || !s_q.ext_ok || s_q.par;
		end else begin
			bad = !s_q.mode;
		end
		addr = ptr_rd;
		upd_data = ptr_rd;
		upd_we = 1'b0;
		case (s_q.op)
			OP_PLAIN: begin
				upd_we = 1'b0;
			end
			OP_POST_INC: begin
				upd_we = 1'b1;
				upd_data = ptr_rd + step;
			end
			OP_POST_DEC: begin
				upd_we = 1'b1;
				upd_data = ptr_rd - step;
			end
			OP_POST_ADD: begin
				upd_we = 1'b1;
				upd_data = ptr_rd + offset;
			end
			OP_BASE_K: begin
				addr = ptr_rd + offset;
			end
			OP_PRE_K: begin
				upd_we = 1'b1;
				upd_data = ptr_rd + offset;
				addr = upd_data;
			end
			default: begin
				bad = 1'b1;
			end
		endcase
		upd_we = upd_we && s_q.vld && !bad;
	end

	// Write-back in the issue slot; a software load takes precedence
	assign pf_we = i_ptr_ld_en || upd_we;
	assign pf_wsel = i_ptr_ld_en ? i_ptr_ld_sel : s_q.sel;
	assign pf_wdata = i_ptr_ld_en ? i_ptr_ld_data : upd_data;

	ar_pointer_file #(
		.NPTR(`AG_NPTR),
		.W(`AG_ADDR_W),
		.NRD(2)
	) u_ptrs (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_we(pf_we),
		.i_wsel(pf_wsel),
		.i_wdata(pf_wdata),
		.i_rsel(rd_sel),
		.o_rdata(rd_data)
	);

	always_comb begin
		s_d = s_q;
		s_d.vld = i_req_valid;
		if (i_req_valid) begin
			s_d.op = i_op;
			s_d.sel = i_ptr_sel;
			s_d.acc = i_access;
			s_d.spc = i_space;
			s_d.mode = i_pointer_mode_select;
			s_d.legacy = i_legacy_compat_mode;
			s_d.tmp = i_temp_reg_zero;
			s_d.konst = i_ext_word;
			s_d.ext_ok = i_ext_valid;
			s_d.par = i_parallel;
		end
		s_d.out_vld = s_q.vld && !bad;
		s_d.out_fault = s_q.vld && bad;
		if (s_q.vld) begin
			s_d.out_addr = addr;
			s_d.out_spc = s_q.spc;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_addr_vld = s_q.out_vld;
	assign o_addr = s_q.out_addr;
	assign o_space = s_q.out_spc;
	assign o_fault = s_q.out_fault;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_srst);

	sequence s_take_k;
		i_req_valid && (i_op == OP_PRE_K || i_op == OP_BASE_K);
	endsequence
	sequence s_stage(op_t op);
		s_q.vld && s_q.op == op && !bad;
	endsequence

	AST_EXT_WORD: assert property (s_take_k |=>
		s_q.konst == $past(i_ext_word))
		else $error("constant not taken from extension word");
	AST_SOLO: assert property ((s_take_k and i_parallel) |->
		##2 (o_fault && !o_addr_vld))
		else $error("paired constant-offset instruction issued");
	AST_PRE_NO_IO: assert property ((s_take_k
		and i_space == SP_IO) |-> ##2 o_fault)
		else $error("constant-offset access to I/O accepted");
	AST_DSP_SET: assert property (i_req_valid && !i_pointer_mode_select
		&& i_op inside {OP_PLAIN, OP_POST_INC, OP_POST_DEC, OP_POST_ADD}
		|-> ##2 (o_fault && !o_addr_vld))
		else $error("control operand accepted in DSP mode");
	AST_CTRL_IO: assert property (i_req_valid && i_pointer_mode_select
		&& i_space == SP_IO && i_op inside {OP_PLAIN, OP_POST_INC,
		OP_POST_DEC, OP_POST_ADD} |-> ##2 (o_addr_vld && o_space == SP_IO))
		else $error("control operand to I/O not issued");
	AST_PRE_ADDR: assert property (s_stage(OP_PRE_K) |->
		upd_we && upd_data == ptr_rd + sext(s_q.konst)
		##1 o_addr == $past(upd_data))
		else $error("premodified address wrong");
	AST_PLAIN: assert property (s_stage(OP_PLAIN) |-> !pf_we ||
		i_ptr_ld_en ##1 o_addr_vld && o_addr == $past(ptr_rd))
		else $error("plain operand changed pointer or address");
	AST_INC: assert property (s_stage(OP_POST_INC) |->
		##1 o_addr_vld && o_addr == $past(ptr_rd))
		else $error("post-increment address not the old pointer");
	AST_STEP: assert property (s_stage(OP_POST_INC) |->
		upd_data - ptr_rd == ((s_q.acc inside {ACC_LONG, ACC_BIT2}) ?
		23'h0_0002 : 23'h0_0001))
		else $error("post-increment step wrong");
	AST_BIT1: assert property ((s_stage(OP_POST_DEC)
		and s_q.acc == ACC_BIT1) |-> ptr_rd - upd_data == 23'h0_0001)
		else $error("single-bit step wrong");
	AST_DEC: assert property ((s_stage(OP_POST_DEC)
		and s_q.acc == ACC_BIT2) |-> ptr_rd - upd_data == 23'h0_0002
		##1 o_addr == $past(ptr_rd))
		else $error("post-decrement wrong");
	AST_ADD_T: assert property ((s_stage(OP_POST_ADD)
		and !s_q.legacy) |->
		upd_data == ptr_rd + {{7{s_q.tmp[15]}}, s_q.tmp})
		else $error("post-add of temp register wrong");
	AST_ADD_LEG: assert property ((s_stage(OP_POST_ADD)
		and s_q.legacy) |-> upd_data == ptr_rd + zero_rd)
		else $error("legacy post-add source wrong");
	AST_BASE_K: assert property (s_stage(OP_BASE_K) |-> !upd_we
		##1 o_addr == $past(ptr_rd) + $past(sext(s_q.konst)))
		else $error("base-plus-constant wrong");
	AST_FWD: assert property (upd_we && !i_ptr_ld_en && i_req_valid
		&& i_ptr_sel == s_q.sel |=> ptr_rd == $past(upd_data))
		else $error("next request missed pointer update");
endmodule

// File: bench/ar_indirect_address_gen_tb.sv
// Self-checking bench for the indirect operand address generator
`timescale 1ns/1ps
module ar_indirect_address_gen_tb;
	import ar_indirect_pkg::*;
	typedef struct packed {
		op_t op;
		access_t acc;
		space_t sp;
		logic [3:0] ctl;
		logic [15:0] off;
		logic [22:0] p;
		logic flt;
		logic [22:0] addr;
		logic [22:0] ptr;
	} row_t;
	logic i_core_clk = 1'b0;
	logic i_srst, i_req_valid, i_pointer_mode_select, i_legacy_compat_mode;
	logic i_ext_valid, i_parallel, i_ptr_ld_en, o_addr_vld, o_fault;
	op_t i_op;
	access_t i_access;
	space_t i_space, o_space;
	logic [2:0] i_ptr_sel, i_ptr_ld_sel;
	logic [15:0] i_temp_reg_zero, i_ext_word;
	logic [22:0] i_ptr_ld_data, o_addr;
	logic [25:0] ans_q[$];
	row_t rows[$];
	row_t rb;
	int n_mismatch = 0;
	int tests_run = 0;

	ar_indirect_address_gen i_ar_indirect_address_gen (
		.i_core_clk, .i_srst, .i_req_valid, .i_op, .i_ptr_sel, .i_access,
		.i_space, .i_pointer_mode_select, .i_legacy_compat_mode,
		.i_temp_reg_zero, .i_ext_word, .i_ext_valid, .i_parallel,
		.i_ptr_ld_en, .i_ptr_ld_sel, .i_ptr_ld_data,
		.o_addr_vld, .o_addr, .o_space, .o_fault
	);

	always #5 i_core_clk = ~i_core_clk;

	// Collect every answer so back-to-back results are kept in order
	always @(posedge i_core_clk) begin
		if (o_addr_vld === 1'b1 || o_fault === 1'b1) begin
			ans_q.push_back({o_fault, o_space, o_addr});
		end
	end

	task automatic test_done();
		$display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk_addr(input logic [22:0] got, input logic [22:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t addr got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t flag got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_space(input space_t got, input space_t exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t space got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic expect_ans(input logic f, input logic [22:0] a,
			input space_t s);
		logic [25:0] v;
		int n;
		n = 0;
		while (ans_q.size() == 0 && n < 8) begin
			@(posedge i_core_clk);
			n++;
		end
		if (ans_q.size() == 0) begin
			n_mismatch++;
			$display("ERROR %0t no answer got %h exp %h", $time, 1'b0, 1'b1);
			test_done();
		end else begin
			v = ans_q.pop_front();
			chk_bit(v[25], f);
			if (!f) begin
				chk_addr(v[22:0], a);
				chk_space(space_t'(v[24:23]), s);
			end
		end
	endtask

	task automatic send(input row_t r, input logic [2:0] sel);
		@(posedge i_core_clk);
		i_req_valid <= 1'b1;
		i_op <= r.op;
		i_ptr_sel <= sel;
		i_access <= r.acc;
		i_space <= r.sp;
		{i_pointer_mode_select, i_legacy_compat_mode} <= r.ctl[3:2];
		{i_ext_valid, i_parallel} <= r.ctl[1:0];
		i_temp_reg_zero <= r.off;
		i_ext_word <= r.off;
	endtask

	task automatic idle();
		@(posedge i_core_clk);
		i_req_valid <= 1'b0;
	endtask

	task automatic load(input logic [2:0] sel, input logic [22:0] d);
		@(posedge i_core_clk);
		i_ptr_ld_en <= 1'b1;
		i_ptr_ld_sel <= sel;
		i_ptr_ld_data <= d;
		@(posedge i_core_clk);
		i_ptr_ld_en <= 1'b0;
	endtask

	// Control bits per row: mode select, legacy, extension present, paired
	task automatic r(input op_t o, input access_t ac, input space_t s,
			input logic [3:0] c, input logic [15:0] k, input logic [22:0] p,
			input logic f, input logic [22:0] a, input logic [22:0] pt);
		rows.push_back(row_t'{o, ac, s, c, k, p, f, a, pt});
	endtask

	task automatic readback(input logic [2:0] sel, input logic [22:0] exp);
		rb.op = OP_PLAIN;
		rb.ctl = 4'hA;
		rb.sp = SP_DATA;
		send(rb, sel);
		idle();
		expect_ans(1'b0, exp, SP_DATA);
	endtask

	initial begin
		{i_srst, i_req_valid, i_ptr_ld_en} = 3'b100;
		{i_pointer_mode_select, i_legacy_compat_mode} = 2'b00;
		{i_ext_valid, i_parallel} = 2'b00;
		i_op = OP_PLAIN;
		i_access = ACC_WORD;
		i_space = SP_DATA;
		{i_ptr_sel, i_ptr_ld_sel, i_ptr_ld_data} = '0;
		{i_temp_reg_zero, i_ext_word} = '0;
		rb = '0;
		r(OP_PLAIN, ACC_WORD, SP_DATA, 4'hA, 16'h0000, 23'h00_0010, 1'b0,
			23'h00_0010, 23'h00_0010);
		r(OP_POST_INC, ACC_WORD, SP_MMR, 4'hA, 16'h0000, 23'h00_0010, 1'b0,
			23'h00_0010, 23'h00_0011);
		r(OP_POST_INC, ACC_LONG, SP_RBIT, 4'hA, 16'h0000, 23'h00_0010, 1'b0,
			23'h00_0010, 23'h00_0012);
		r(OP_POST_INC, ACC_BIT1, SP_IO, 4'hA, 16'h0000, 23'h00_0010, 1'b0,
			23'h00_0010, 23'h00_0011);
		r(OP_POST_INC, ACC_BIT2, SP_DATA, 4'hA, 16'h0000, 23'h00_0010, 1'b0,
			23'h00_0010, 23'h00_0012);
		r(OP_POST_DEC, ACC_WORD, SP_DATA, 4'hA, 16'h0000, 23'h00_0000, 1'b0,
			23'h00_0000, 23'h7F_FFFF);
		r(OP_POST_DEC, ACC_LONG, SP_IO, 4'hA, 16'h0000, 23'h00_0010, 1'b0,
			23'h00_0010, 23'h00_000E);
		r(OP_POST_DEC, ACC_BIT1, SP_RBIT, 4'hA, 16'h0000, 23'h00_0010, 1'b0,
			23'h00_0010, 23'h00_000F);
		r(OP_POST_DEC, ACC_BIT2, SP_RBIT, 4'hA, 16'h0000, 23'h00_0010, 1'b0,
			23'h00_0010, 23'h00_000E);
		r(op_t'(3'b110), ACC_WORD, SP_DATA, 4'hA, 16'h0000, 23'h00_0010,
			1'b1, 23'h00_0000, 23'h00_0010);
		r(OP_POST_ADD, ACC_WORD, SP_DATA, 4'hA, 16'hFFFE, 23'h00_0010, 1'b0,
			23'h00_0010, 23'h00_000E);
		r(OP_POST_ADD, ACC_WORD, SP_MMR, 4'hE, 16'h0005, 23'h00_0010, 1'b0,
			23'h00_0010, 23'h00_0110);
		r(OP_PRE_K, ACC_WORD, SP_DATA, 4'h2, 16'hFFFF, 23'h00_0010, 1'b0,
			23'h00_000F, 23'h00_000F);
		r(OP_PRE_K, ACC_LONG, SP_MMR, 4'hA, 16'h8000, 23'h00_0010, 1'b0,
			23'h7F_8010, 23'h7F_8010);
		r(OP_BASE_K, ACC_WORD, SP_RBIT, 4'h2, 16'h0020, 23'h00_0010, 1'b0,
			23'h00_0030, 23'h00_0010);
		r(OP_PRE_K, ACC_WORD, SP_IO, 4'h2, 16'h0001, 23'h00_0010, 1'b1,
			23'h00_0000, 23'h00_0010);
		r(OP_PRE_K, ACC_WORD, SP_DATA, 4'h0, 16'h0001, 23'h00_0010, 1'b1,
			23'h00_0000, 23'h00_0010);
		r(OP_BASE_K, ACC_WORD, SP_DATA, 4'h3, 16'h0001, 23'h00_0010, 1'b1,
			23'h00_0000, 23'h00_0010);
		r(OP_POST_INC, ACC_WORD, SP_DATA, 4'h2, 16'h0000, 23'h00_0010, 1'b1,
			23'h00_0000, 23'h00_0010);
		repeat (3) @(posedge i_core_clk);
		i_srst <= 1'b0;
		@(posedge i_core_clk);
		chk_bit(o_addr_vld, 1'b0);
		chk_bit(o_fault, 1'b0);
		chk_addr(o_addr, 23'h00_0000);
		chk_space(o_space, SP_DATA);
		readback(3'h3, 23'h00_0000);
		$display("reset test done");
		load(3'h0, 23'h00_0100);
		foreach (rows[i]) begin
			load(3'h3, rows[i].p);
			send(rows[i], 3'h3);
			idle();
			expect_ans(rows[i].flt, rows[i].addr, rows[i].sp);
			readback(3'h3, rows[i].ptr);
			$display("row %0d test done", i);
		end
		load(3'h5, 23'h00_0020);
		send(rows[2], 3'h5);
		send(rows[2], 3'h5);
		idle();
		expect_ans(1'b0, 23'h00_0020, SP_RBIT);
		expect_ans(1'b0, 23'h00_0022, SP_RBIT);
		readback(3'h5, 23'h00_0024);
		$display("back-to-back test done");
		@(posedge i_core_clk);
		i_srst <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		i_srst <= 1'b0;
		readback(3'h5, 23'h00_0000);
		$display("mid-run reset test done");
		test_done();
	end
endmodule
